/* File: ddc_pkg.sv */
// shared constants for the drive control signalling block
package ddc_pkg;
  localparam int          CLK_HZ          = 50000000;
  // step pulse low time and direction setup, in ns
  localparam int          STEP_LOW_NS     = 1000;
  localparam int          DIR_SETUP_NS    = 1000;
  localparam int          STEP_LOW_CYC    = (STEP_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          DIR_SETUP_CYC   = (DIR_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0]  STEP_LOW_CNT    = 8'(STEP_LOW_CYC);
  localparam logic [7:0]  DIR_SETUP_CNT   = 8'(DIR_SETUP_CYC);
  // floppy track zones
  localparam logic [6:0]  RWC_TRK_LO      = 7'h2B;
  localparam logic [6:0]  ARC_TRK_LO      = 7'h3C;
  localparam logic [6:0]  FLOPPY_TRK_HI   = 7'h4C;
  // drive class from which the shared line is head bit 3
  localparam logic [3:0]  HEAD3_CLASS_MIN = 4'h5;
  localparam int          FIFO_WIDTH      = 1;
  localparam int          FIFO_DEPTH      = 4;
  typedef enum logic [1:0] {DDC_ST_IDLE, DDC_ST_SETUP, DDC_ST_LOW, DDC_ST_GAP} ddc_step_t;
endpackage

/* File: ddc_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module ddc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];

  // next fill count; ready is registered from it so the pin leaves a flop
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // storage, written by index
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff   <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff   <= nxt_cnt;
      in_ready <= (nxt_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule

/* File: ddc_ctrl.sv */
// drive control signalling: hard disk and floppy control lines, step, write serialiser
// How it works
// - hard head number on active-low lines; top line shared with low current
// - shared hard line low requests lower write current
// - hard write gate low only to write; high allows read and stepping
// - hard drive usable only when ready and seek done both low
// - each step moves heads one track; direction low means inward
// - at most one of two drive selects active
// - floppy write to tracks 43-76 drives reduce current low
// - floppy read of tracks 60-76 drives read compensation low
// - side select low accesses side 1, high side 0
// - head load low loads heads if door closed
// - each falling write-data edge writes one bit under write gate
// - floppy write gate low enables writing, high enables reading
// - raw read data transitions; controller separates clock and data
// - data port select low connects drive to differential data
`timescale 1ns/10ps
module ddc_ctrl (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // controller-side commands
  input  wire logic       sel_floppy,
  input  wire logic       drive_sel_valid,
  input  wire logic       drive_sel_b,
  input  wire logic [3:0] head_num,
  input  wire logic [3:0] drive_class,
  input  wire logic [6:0] track_num,
  input  wire logic       side_one,
  input  wire logic       head_load,
  input  wire logic       write_mode,
  input  wire logic       step_req,
  input  wire logic       step_inward,
  input  wire logic       wr_bit,
  input  wire logic       wr_bit_valid,
  input  wire logic       bit_tick,
  // drive status pins, asynchronous
  input  wire logic       seek_done_n,
  input  wire logic       at_track_zero_n,
  input  wire logic       write_fault_n,
  input  wire logic       index_n,
  input  wire logic       ready_n,
  input  wire logic       media_changed_n,
  input  wire logic       write_protect_n,
  input  wire logic       read_data_n,
  // drive control pins
  output logic            head_bit3_or_low_current,
  output logic            head_bit2,
  output logic            head_bit1,
  output logic            head_bit0,
  output logic            write_gate_n,
  output logic            drive_select_a_n,
  output logic            drive_select_b_n,
  output logic            step_n,
  output logic            step_direction_n,
  output logic            side_select_n,
  output logic            head_load_n,
  output logic            write_data_n,
  output logic            data_port_select_a_n,
  output logic            data_port_select_b_n,
  // status back to the controller
  output logic            wr_bit_ready,
  output logic            step_busy,
  output logic            hard_ready,
  output logic            track_zero,
  output logic            write_fault,
  output logic            index_pulse,
  output logic            floppy_ready,
  output logic            media_changed,
  output logic            write_protected,
  output logic            read_edge
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic       idx_prev_ff;
  logic       rd_prev_ff;

  // two flops per pin; only the second stage is read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 8'hFF;
      sync2_ff <= 8'hFF;
    end else begin
      sync1_ff <= {read_data_n, write_protect_n, media_changed_n, ready_n,
                   index_n, write_fault_n, at_track_zero_n, seek_done_n};
      sync2_ff <= sync1_ff;
    end
  end

  // edge memories for index and raw read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_prev_ff <= 1'b1;
      rd_prev_ff  <= 1'b1;
    end else begin
      idx_prev_ff <= sync2_ff[3];
      rd_prev_ff  <= sync2_ff[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs, registered
  // hard drive readiness
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hard_ready      <= 1'b0;
      track_zero      <= 1'b0;
      write_fault     <= 1'b0;
      index_pulse     <= 1'b0;
      floppy_ready    <= 1'b0;
      media_changed   <= 1'b0;
      write_protected <= 1'b0;
      read_edge       <= 1'b0;
    end else begin
      hard_ready      <= !sel_floppy && !sync2_ff[4] && !sync2_ff[0];
      track_zero      <= !sync2_ff[1];
      write_fault     <= !sync2_ff[2];
      // one pulse per falling index edge
      index_pulse     <= idx_prev_ff && !sync2_ff[3];
      floppy_ready    <= sel_floppy && !sync2_ff[4];
      media_changed   <= !sync2_ff[5];
      write_protected <= !sync2_ff[6];
      // raw falling edges handed on unseparated
      read_edge       <= rd_prev_ff && !sync2_ff[7] && write_gate_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selection and head lines
  function automatic logic in_zone(input logic [6:0] trk, input logic [6:0] lo);
    in_zone = (trk >= lo) && (trk <= ddc_pkg::FLOPPY_TRK_HI);
  endfunction

  logic gate_on;
  assign gate_on = write_mode;

  logic shared_line;
  // shared top line: head bit 3, reduce current or read compensation
  always_comb begin
    if (sel_floppy) begin
      shared_line = write_mode ? !in_zone(track_num, ddc_pkg::RWC_TRK_LO)
                               : !in_zone(track_num, ddc_pkg::ARC_TRK_LO);
    end else if (drive_class >= ddc_pkg::HEAD3_CLASS_MIN) begin
      shared_line = !head_num[3];
    end else begin
      shared_line = !write_mode;
    end
  end

  // control pins, all registered; selects never both low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      head_bit3_or_low_current <= 1'b1;
      head_bit2                <= 1'b1;
      head_bit1                <= 1'b1;
      head_bit0                <= 1'b1;
      drive_select_a_n         <= 1'b1;
      drive_select_b_n         <= 1'b1;
      data_port_select_a_n     <= 1'b1;
      data_port_select_b_n     <= 1'b1;
      side_select_n            <= 1'b1;
      head_load_n              <= 1'b1;
      write_gate_n             <= 1'b1;
    end else begin
      head_bit3_or_low_current <= shared_line;
      head_bit2                <= !head_num[2];
      head_bit1                <= !head_num[1];
      head_bit0                <= !head_num[0];
      drive_select_a_n         <= !(drive_sel_valid && !drive_sel_b);
      drive_select_b_n         <= !(drive_sel_valid && drive_sel_b);
      // data port follows hard drive select
      data_port_select_a_n     <= !(drive_sel_valid && !drive_sel_b && !sel_floppy);
      data_port_select_b_n     <= !(drive_sel_valid && drive_sel_b && !sel_floppy);
      side_select_n            <= !(sel_floppy && side_one);
      head_load_n              <= !(sel_floppy && head_load);
      // gate low only while writing and idle stepper
      // floppy gate selects write over read
      write_gate_n             <= !(gate_on && drive_sel_valid && !step_busy);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stepper: direction, setup, pulse, recovery
  ddc_pkg::ddc_step_t st_ff;
  logic [7:0]         stcnt_ff;

  // direction first, never with gate active
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff            <= ddc_pkg::DDC_ST_IDLE;
      stcnt_ff         <= 8'h00;
      step_n           <= 1'b1;
      step_direction_n <= 1'b1;
      step_busy        <= 1'b0;
    end else begin
      case (st_ff)
        ddc_pkg::DDC_ST_IDLE: begin
          if (step_req && write_gate_n && !write_mode) begin
            step_direction_n <= !step_inward;
            stcnt_ff         <= ddc_pkg::DIR_SETUP_CNT;
            step_busy        <= 1'b1;
            st_ff            <= ddc_pkg::DDC_ST_SETUP;
          end
        end
        ddc_pkg::DDC_ST_SETUP: begin
          if (stcnt_ff <= 8'h01) begin
            step_n   <= 1'b0;
            stcnt_ff <= ddc_pkg::STEP_LOW_CNT;
            st_ff    <= ddc_pkg::DDC_ST_LOW;
          end else begin
            stcnt_ff <= stcnt_ff - 8'h01;
          end
        end
        ddc_pkg::DDC_ST_LOW: begin
          if (stcnt_ff <= 8'h01) begin
            step_n   <= 1'b1;
            stcnt_ff <= ddc_pkg::STEP_LOW_CNT;
            st_ff    <= ddc_pkg::DDC_ST_GAP;
          end else begin
            stcnt_ff <= stcnt_ff - 8'h01;
          end
        end
        default: begin
          // recovery gap so back-to-back steps stay separate pulses
          if (stcnt_ff <= 8'h01) begin
            step_busy <= 1'b0;
            st_ff     <= ddc_pkg::DDC_ST_IDLE;
          end else begin
            stcnt_ff <= stcnt_ff - 8'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write data path: bits buffered, one bit per bit_tick
  logic fifo_bit;
  logic fifo_valid;
  logic take_bit;
  logic low_phase_ff;

  ddc_fifo #(
    .WIDTH (ddc_pkg::FIFO_WIDTH),
    .DEPTH (ddc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (wr_bit),
    .in_valid  (wr_bit_valid),
    .in_ready  (wr_bit_ready),
    .out_data  (fifo_bit),
    .out_valid (fifo_valid),
    .out_ready (take_bit)
  );

  // drain only while the gate is low and stays low, so no edge meets a rising gate
  assign take_bit = bit_tick && !write_gate_n && gate_on && drive_sel_valid && !low_phase_ff;

  // a one bit gives one falling edge, back high next cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_data_n <= 1'b1;
      low_phase_ff <= 1'b0;
    end else if (low_phase_ff || write_gate_n) begin
      write_data_n <= 1'b1;
      low_phase_ff <= 1'b0;
    end else if (take_bit && fifo_valid && fifo_bit) begin
      write_data_n <= 1'b0;
      low_phase_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_SEL_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
    !(!drive_select_a_n && !drive_select_b_n))
    else $error("both drive selects active");

  AST_NO_STEP_WG: assert property (@(posedge clk) disable iff (sys_rst)
    !step_n |-> write_gate_n)
    else $error("step pulse with write gate active");

  AST_DIR_HELD: assert property (@(posedge clk) disable iff (sys_rst)
    !step_n |-> $stable(step_direction_n))
    else $error("direction changed during step");

  AST_WD_GATED: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(write_data_n) |-> !write_gate_n)
    else $error("write data edge without gate");

  AST_WD_SHORT: assert property (@(posedge clk) disable iff (sys_rst)
    !write_data_n |=> write_data_n)
    else $error("write data low too long");

  AST_HARD_RDY: assert property (@(posedge clk) disable iff (sys_rst)
    hard_ready |-> $past(!sync2_ff[4] && !sync2_ff[0]))
    else $error("hard ready without ready and seek done");

  AST_SIDE: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sel_floppy && side_one) |-> !side_select_n)
    else $error("side one not selected");

  AST_RWC_ZONE: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sel_floppy && write_mode && track_num >= ddc_pkg::RWC_TRK_LO && track_num <= ddc_pkg::FLOPPY_TRK_HI)
      |-> !head_bit3_or_low_current)
    else $error("reduce current missing in zone");

  AST_ARC_ZONE: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sel_floppy && !write_mode && track_num < ddc_pkg::ARC_TRK_LO) |-> head_bit3_or_low_current)
    else $error("read compensation outside zone");

  AST_WG_MODE: assert property (@(posedge clk) disable iff (sys_rst)
    !write_gate_n |-> $past(write_mode))
    else $error("write gate without write mode");

  AST_LOWCUR: assert property (@(posedge clk) disable iff (sys_rst)
    $past(!sel_floppy && write_mode && drive_class < ddc_pkg::HEAD3_CLASS_MIN) |-> !head_bit3_or_low_current)
    else $error("low current not requested");

  AST_HEAD: assert property (@(posedge clk) disable iff (sys_rst)
    head_bit0 == !$past(head_num[0]))
    else $error("head bit 0 wrong");

  AST_DPS: assert property (@(posedge clk) disable iff (sys_rst)
    !data_port_select_a_n |-> !drive_select_a_n)
    else $error("data port without drive select");

  AST_HL: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sel_floppy && head_load) |-> !head_load_n)
    else $error("head load not driven");
endmodule

/* File: ddc_drive_model.sv */
// behavioural drive model: stepper, index, ready, raw read data, bit counter
`timescale 1ns/10ps
module ddc_drive_model #(
  parameter int REV_CYC = 192, // multiple of the 16-cycle read pattern, no double edge at wrap
  parameter int N_IDX   = 2
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic step_n,
  input  wire logic step_direction_n,
  input  wire logic drive_select_a_n,
  input  wire logic write_gate_n,
  input  wire logic write_data_n,
  input  wire logic swap_media,
  input  wire logic protect,
  output logic      seek_done_n,
  output logic      at_track_zero_n,
  output logic      write_fault_n,
  output logic      index_n,
  output logic      ready_n,
  output logic      media_changed_n,
  output logic      write_protect_n,
  output logic      read_data_n,
  output int        trk_ff,
  output int        wr_cnt_ff
);
  logic step_d_ff;
  logic wd_d_ff;
  int   rev_ff;
  int   idx_cnt_ff;
  int   settle_ff;
  ////////////////////////////////////////////////////////////
  // static pin levels
  assign write_protect_n = ~protect;
  // track zero only at track zero
  assign at_track_zero_n = (trk_ff != 0);
  // seek done once heads have settled
  assign seek_done_n = (settle_ff != 0);
  assign index_n = (rev_ff >= 2);
  assign read_data_n = ((rev_ff % 16) != 0);
  ////////////////////////////////////////////////////////////
  // one track per step, low direction inward
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_d_ff <= 1'b1;
      trk_ff    <= 1;
      settle_ff <= 0;
    end else begin
      step_d_ff <= step_n;
      if (step_d_ff && !step_n) begin
        trk_ff    <= step_direction_n ? ((trk_ff > 0) ? trk_ff - 1 : 0) : trk_ff + 1;
        settle_ff <= 20;
      end else if (settle_ff != 0) begin
        settle_ff <= settle_ff - 1;
      end
    end
  end
  // ready only after N_IDX index holes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rev_ff     <= 5;
      idx_cnt_ff <= 0;
      ready_n    <= 1'b1;
    end else begin
      rev_ff <= (rev_ff == REV_CYC - 1) ? 0 : rev_ff + 1;
      if (rev_ff == 1 && idx_cnt_ff < N_IDX) begin
        idx_cnt_ff <= idx_cnt_ff + 1;
        ready_n    <= (idx_cnt_ff != N_IDX - 1);
      end
    end
  end
  // bits under gate, fault without gate; media flag sticks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_d_ff         <= 1'b1;
      wr_cnt_ff       <= 0;
      write_fault_n   <= 1'b1;
      media_changed_n <= 1'b1;
    end else begin
      wd_d_ff <= write_data_n;
      if (wd_d_ff && !write_data_n && !write_gate_n) wr_cnt_ff <= wr_cnt_ff + 1;
      if (wd_d_ff && !write_data_n && write_gate_n) write_fault_n <= 1'b0;
      if (swap_media && drive_select_a_n) media_changed_n <= 1'b0;
    end
  end
endmodule

/* File: ddc_ctrl_tb.sv */
// self-checking bench for the drive control block against its drive model
`timescale 1ns/10ps
module ddc_ctrl_tb;
  logic       clk, sys_rst, sel_floppy, drive_sel_valid, drive_sel_b, side_one, head_load;
  logic       write_mode, step_req, step_inward, wr_bit, wr_bit_valid, bit_tick, swap_media, protect;
  logic [3:0] head_num, drive_class;
  logic [6:0] track_num;
  logic       seek_done_n, at_track_zero_n, write_fault_n, index_n, ready_n, media_changed_n;
  logic       write_protect_n, read_data_n, head_bit3_or_low_current, head_bit2, head_bit1, head_bit0;
  logic       write_gate_n, drive_select_a_n, drive_select_b_n, step_n, step_direction_n, side_select_n;
  logic       head_load_n, write_data_n, data_port_select_a_n, data_port_select_b_n, wr_bit_ready;
  logic       step_busy, hard_ready, track_zero, write_fault, index_pulse, floppy_ready;
  logic       media_changed, write_protected, read_edge;
  int         trk, wr_cnt, error_cnt, n_compared;
  ddc_ctrl ddc_ctrl_inst (.clk, .sys_rst, .sel_floppy, .drive_sel_valid, .drive_sel_b, .head_num,
    .drive_class, .track_num, .side_one, .head_load, .write_mode, .step_req, .step_inward, .wr_bit,
    .wr_bit_valid, .bit_tick, .seek_done_n, .at_track_zero_n, .write_fault_n, .index_n, .ready_n,
    .media_changed_n, .write_protect_n, .read_data_n, .head_bit3_or_low_current, .head_bit2,
    .head_bit1, .head_bit0, .write_gate_n, .drive_select_a_n, .drive_select_b_n, .step_n,
    .step_direction_n, .side_select_n, .head_load_n, .write_data_n, .data_port_select_a_n,
    .data_port_select_b_n, .wr_bit_ready, .step_busy, .hard_ready, .track_zero, .write_fault,
    .index_pulse, .floppy_ready, .media_changed, .write_protected, .read_edge);
  ddc_drive_model ddc_drive_model_inst (.clk, .sys_rst, .step_n, .step_direction_n, .drive_select_a_n,
    .write_gate_n, .write_data_n, .swap_media, .protect, .seek_done_n, .at_track_zero_n,
    .write_fault_n, .index_n, .ready_n, .media_changed_n, .write_protect_n, .read_data_n,
    .trk_ff(trk), .wr_cnt_ff(wr_cnt));
  ////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // index holes counted before floppy ready, then hard ready qualification
  task automatic t_ready;
    int n;
    int k;
    n = 0;
    k = 0;
    chk({2'b0, write_gate_n, step_n, write_data_n, head_load_n, drive_select_a_n, drive_select_b_n},
        8'h3F, "idle pins after reset");
    while (!floppy_ready && k < 1000) begin
      cyc(1);
      k++;
      if (index_pulse === 1'b1) n++;
    end
    chk(8'(n), 8'h02, "index holes before ready");
    sel_floppy = 0;
    cyc(4);
    chk(hard_ready, 1, "hard ready");
    $display("test ready done");
  endtask
  // head number, shared line, drive and data port selects
  task automatic t_head;
    drive_sel_valid = 1;
    drive_class = 4'h5;
    for (int h = 0; h < 16; h++) begin
      head_num = 4'(h);
      cyc(2);
      chk({head_bit3_or_low_current, head_bit2, head_bit1, head_bit0}, {4'h0, ~head_num}, "head");
    end
    drive_class = 4'h2;
    head_num = 4'h3;
    write_mode = 1;
    cyc(2);
    chk({head_bit3_or_low_current, head_bit2, head_bit1, head_bit0}, 8'h04, "low current");
    chk({drive_select_a_n, drive_select_b_n, data_port_select_a_n, data_port_select_b_n}, 8'h05, "sel a");
    drive_sel_b = 1;
    cyc(2);
    chk({drive_select_a_n, drive_select_b_n, data_port_select_a_n, data_port_select_b_n}, 8'h0A, "sel b");
    drive_sel_valid = 0;
    cyc(2);
    chk({drive_select_a_n, drive_select_b_n, write_gate_n}, 8'h07, "no drive, no gate");
    write_mode = 0;
    drive_sel_b = 0;
    drive_sel_valid = 1;
    cyc(2);
    chk(head_bit3_or_low_current, 1, "normal current");
    $display("test head done");
  endtask
  // floppy zones at their boundary tracks, side and head load
  task automatic t_zone;
    logic [6:0] trks [6];
    trks = '{7'h2A, 7'h2B, 7'h4C, 7'h3B, 7'h3C, 7'h4C};
    sel_floppy = 1;
    for (int i = 0; i < 6; i++) begin
      write_mode = (i < 3);
      track_num = trks[i];
      cyc(2);
      chk(head_bit3_or_low_current, !(track_num >= (write_mode ? 7'h2B : 7'h3C) && track_num <= 7'h4C), "zone");
    end
    write_mode = 0;
    for (int i = 0; i < 2; i++) begin
      side_one = !i;
      head_load = !i;
      cyc(2);
      chk({side_select_n, head_load_n}, {6'h0, i[0], i[0]}, "side and load");
    end
    $display("test zone done");
  endtask
  // one step: direction first, timed low pulse, seek, track moved
  task automatic t_step(input logic inward);
    int n;
    int t0;
    t0 = trk;
    step_inward = inward;
    step_req = 1;
    cyc(1);
    step_req = 0;
    cyc(1);
    chk({step_busy, step_direction_n}, {6'h0, 1'b1, !inward}, "busy and direction");
    // the check edge above already counts as one setup cycle
    n = 1;
    while (step_n && n < 300) begin
      cyc(1);
      n++;
    end
    chk(8'(n), 8'(ddc_pkg::DIR_SETUP_CYC), "direction setup");
    n = 0;
    while (!step_n && n < 300) begin
      cyc(1);
      n++;
      if (n == 10) chk(hard_ready, 0, "not ready in seek");
    end
    chk(8'(n), 8'(ddc_pkg::STEP_LOW_CYC), "step low width");
    n = 0;
    while (step_busy && n < 300) begin
      cyc(1);
      n++;
    end
    chk(8'(trk), 8'(t0 + (inward ? 1 : -1)), "track moved");
    $display("test step done");
  endtask
  // no step while writing, then out to track zero
  task automatic t_seek;
    t_step(1);
    t_step(0);
    write_mode = 1;
    step_req = 1;
    cyc(3);
    step_req = 0;
    chk({step_busy, write_gate_n}, 8'h00, "step refused in write");
    write_mode = 0;
    cyc(2);
    t_step(0);
    cyc(4);
    chk(track_zero, 1, "track zero");
    $display("test seek done");
  endtask
  // fill fifo until refused, drain under gate, read edges only with gate high
  task automatic t_write;
    logic [3:0] pat;
    int         n;
    int         w0;
    pat = 4'b1101;
    w0 = wr_cnt;
    n = 0;
    sel_floppy = 1;
    write_mode = 1;
    cyc(2);
    chk(write_gate_n, 0, "gate low");
    for (int i = 0; i < 6; i++) begin
      wr_bit = pat[i % 4];
      wr_bit_valid = 1;
      if (wr_bit_ready === 1'b1) n++;
      cyc(1);
    end
    wr_bit_valid = 0;
    chk(8'(n), 8'(ddc_pkg::FIFO_DEPTH), "fifo refuses when full");
    n = 0;
    for (int i = 0; i < 4; i++) begin
      bit_tick = 1;
      cyc(1);
      bit_tick = 0;
      for (int j = 0; j < 15; j++) begin
        if (read_edge === 1'b1) n++;
        cyc(1);
      end
    end
    chk(8'(n), 8'h00, "no read edges while writing");
    chk({wr_bit_ready, write_fault}, 8'h02, "drained, no fault");
    chk(8'(wr_cnt - w0), 8'h03, "bits written");
    write_mode = 0;
    cyc(4);
    n = 0;
    for (int i = 0; i < 64; i++) begin
      if (read_edge === 1'b1) n++;
      cyc(1);
    end
    chk(8'(n), 8'h04, "read edges");
    $display("test write done");
  endtask
  // protect and media change while deselected
  task automatic t_media;
    protect = 1;
    drive_sel_valid = 0;
    cyc(2);
    swap_media = 1;
    cyc(1);
    swap_media = 0;
    cyc(4);
    chk({write_protected, media_changed}, 8'h03, "protect and change");
    $display("test media done");
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clk, sel_floppy, drive_sel_valid, drive_sel_b, side_one, head_load, write_mode} = '0;
    {step_req, step_inward, wr_bit, wr_bit_valid, bit_tick, swap_media, protect} = '0;
    {head_num, drive_class, track_num} = '0;
    error_cnt = 0;
    n_compared = 0;
    sys_rst = 1;
    sel_floppy = 1;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 0;
    cyc(1);
    t_ready();
    t_head();
    sel_floppy = 0;
    t_seek();
    t_zone();
    t_write();
    t_media();
    complete_run();
  end
  // watchdog, far beyond the roughly one thousand cycles the tests need
  initial begin
    #(20 * 20000);
    error_cnt++;
    $display("FAIL t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule
